//--- oscsc_clock_ctrl.sv
// clock source control: registers, source switching and clock ticks
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
module oscsc_clock_ctrl #(
  parameter logic [13:0] XT_START_SPEEDUP = oscsc_pkg::XT_START_SPEEDUP,
  parameter logic [13:0] XT_START_LOWPWR = oscsc_pkg::XT_START_LOWPWR
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic cpu_halt,
  input wire logic crystal_pin_in_level,
  input wire logic crystal_pin_out_level,
  output logic crystal_pin_in_drive,
  output logic crystal_pin_in_oe,
  output logic crystal_pin_out_drive,
  output logic crystal_pin_out_oe,
  output logic sys_tick,
  output logic fast_tick,
  output logic tbase_tick,
  output logic wdt_tick,
  output logic fast_rc_run,
  output logic crystal_run,
  output logic crystal_stable,
  output logic crystal_low_power
);
  logic [7:0] scc_q;
  logic [7:0] frc_q;
  logic [7:0] xtc_q;
  logic [7:0] pin_q;
  logic sel_scc;
  logic sel_frc;
  logic sel_xtc;
  logic sel_pin;
  logic [7:0] rd_mux;
  logic [7:0] fast_stat;
  logic [7:0] xt_stat;
  logic [7:0] pin_stat;
  logic [7:0] xtc_mask;

  logic [2:0] div_code;
  logic slow_is_crystal;
  logic fast_idle_en;
  logic slow_idle_en;
  logic [1:0] freq_sel;
  logic fast_rc_en;
  logic xt_en;
  logic xt_speedup;

  logic [1:0] pin_lvl;
  logic xt1_s;
  logic xt1_prev_q;
  logic xt_edge;
  logic [13:0] xt_limit;
  logic [13:0] xt_cnt_q;
  logic xt_done;
  logic xt_stable_q;
  logic xt_tick;
  logic xt_mode_lock;
  logic pin_gpio;

  logic [31:0] fast_inc;
  logic fast_raw;
  logic slow_rc_osc_raw;
  logic fsub_raw;
  logic sub_on;
  logic fast_run_d;
  logic [5:0] div_cnt_q;
  logic [5:0] div_mask;
  logic div_tick;
  logic src_raw;

  oscsc_pkg::oscsc_src_t src_q;
  oscsc_pkg::oscsc_src_t src_d;
  oscsc_pkg::oscsc_src_t src_tgt;
  logic tgt_ready;

  // register decode and fields
  assign sel_scc = addr == oscsc_pkg::ADDR_SYSCLK_CTRL;
  assign sel_frc = addr == oscsc_pkg::ADDR_FAST_RC_CTRL;
  assign sel_xtc = addr == oscsc_pkg::ADDR_CRYSTAL_CTRL;
  assign sel_pin = addr == oscsc_pkg::ADDR_PIN_SHARE;

  assign div_code = scc_q[oscsc_pkg::SCC_DIV_LSB +: 3];
  assign slow_is_crystal = scc_q[oscsc_pkg::SCC_SRC_BIT];
  assign fast_idle_en = scc_q[oscsc_pkg::SCC_FAST_IDLE_BIT];
  assign slow_idle_en = scc_q[oscsc_pkg::SCC_SLOW_IDLE_BIT];
  assign freq_sel = frc_q[oscsc_pkg::FRC_FREQ_LSB +: 2];
  assign fast_rc_en = frc_q[oscsc_pkg::FRC_EN_BIT];
  assign xt_en = xtc_q[oscsc_pkg::XTC_EN_BIT];
  assign xt_speedup = xtc_q[oscsc_pkg::XTC_SPEEDUP_BIT];

  // speed-up bit ignores writes while the crystal drives the system
  assign xt_mode_lock = src_q == oscsc_pkg::SRC_CRYSTAL; // R10 R09
  assign xtc_mask = xt_mode_lock ?
    (oscsc_pkg::XTC_WMASK & ~(8'h01 << oscsc_pkg::XTC_SPEEDUP_BIT)) :
    oscsc_pkg::XTC_WMASK; // R10

  assign fast_stat = {7'h00, fast_rc_run} << oscsc_pkg::FRC_STABLE_BIT;
  assign xt_stat = {7'h00, xt_stable_q} << oscsc_pkg::XTC_STABLE_BIT;
  assign pin_stat = {6'h00, pin_lvl} << oscsc_pkg::PIN_IN1_BIT;

  assign rd_mux = sel_scc ? scc_q :
                  sel_frc ? (frc_q | fast_stat) :
                  sel_xtc ? (xtc_q | xt_stat) :
                  sel_pin ? (pin_q | pin_stat) : 8'h00;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scc_q <= oscsc_pkg::RST_SYSCLK_CTRL;
      frc_q <= oscsc_pkg::RST_FAST_RC_CTRL;
      xtc_q <= oscsc_pkg::RST_CRYSTAL_CTRL;
      pin_q <= oscsc_pkg::RST_PIN_SHARE;
    end else if (wr_en) begin
      if (sel_scc) begin
        scc_q <= wdata & oscsc_pkg::SCC_WMASK; // R04 R05
      end
      if (sel_frc) begin
        frc_q <= wdata & oscsc_pkg::FRC_WMASK;
      end
      if (sel_xtc) begin
        xtc_q <= (xtc_q & ~xtc_mask) | (wdata & xtc_mask); // R06 R07
      end
      if (sel_pin) begin
        pin_q <= wdata & oscsc_pkg::PIN_WMASK;
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd_en ? rd_mux : 8'h00;
    end
  end

  // crystal pins, sampled through two flops
  oscsc_sync2 #(.W(2)) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({crystal_pin_out_level, crystal_pin_in_level}),
    .q(pin_lvl)
  );

  assign xt1_s = pin_lvl[0];
  assign xt_edge = xt1_s & ~xt1_prev_q;

  // low power mode only lengthens the start-up count
  assign xt_limit = xt_speedup ? XT_START_SPEEDUP : XT_START_LOWPWR; // R07 R11
  assign xt_done = xt_edge && (xt_cnt_q >= xt_limit - 14'h0001);
  assign xt_tick = xt_edge & xt_stable_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      xt1_prev_q <= 1'b0;
      xt_cnt_q <= 14'h0000;
      xt_stable_q <= 1'b0;
    end else begin
      xt1_prev_q <= xt1_s;
      if (!xt_en) begin
        xt_cnt_q <= 14'h0000;
        xt_stable_q <= 1'b0;
      end else if (xt_edge && !xt_stable_q) begin // R08
        xt_cnt_q <= xt_cnt_q + 14'h0001; // R06
        xt_stable_q <= xt_done; // R17
      end
    end
  end

  // pin sharing: general I/O only when the crystal is off
  assign pin_gpio = ~xt_en & pin_q[oscsc_pkg::PIN_GPIO_BIT]; // R12

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      crystal_pin_in_drive <= 1'b0;
      crystal_pin_in_oe <= 1'b0;
      crystal_pin_out_drive <= 1'b0;
      crystal_pin_out_oe <= 1'b0;
    end else begin
      crystal_pin_in_drive <= pin_gpio & pin_q[oscsc_pkg::PIN_OUT1_BIT];
      crystal_pin_in_oe <= pin_gpio & pin_q[oscsc_pkg::PIN_OE1_BIT]; // R12
      crystal_pin_out_drive <= xt_en ? ~xt1_s :
        (pin_gpio & pin_q[oscsc_pkg::PIN_OUT2_BIT]);
      crystal_pin_out_oe <= xt_en |
        (pin_gpio & pin_q[oscsc_pkg::PIN_OE2_BIT]); // R12
    end
  end

  // fast rc frequency select; code 11 falls back to 8 MHz
  assign fast_inc = (freq_sel == oscsc_pkg::FREQ_12) ? oscsc_pkg::INC_FAST_12 :
                    (freq_sel == oscsc_pkg::FREQ_16) ? oscsc_pkg::INC_FAST_16 :
                    oscsc_pkg::INC_FAST_8; // R02

  oscsc_phase_tick u_fast_rc (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(fast_rc_run),
    .inc(fast_inc),
    .tick(fast_raw)
  ); // R01

  // slow rc never stops: the watchdog depends on it
  oscsc_phase_tick u_slow_rc (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(1'b1),
    .inc(oscsc_pkg::INC_SLOW_RC),
    .tick(slow_rc_osc_raw)
  ); // R01 R16

  // fast rc on while selected or enabled; halt keeps it only if idle-enabled
  assign fast_run_d = cpu_halt ? fast_idle_en :
    ((div_code != oscsc_pkg::DIV_SLOW) | fast_rc_en |
     (src_q == oscsc_pkg::SRC_FAST)); // R14

  // divide by 1, 2, 4 .. 64 for codes 000 to 110
  assign div_mask = 6'((7'h01 << div_code) - 7'h01);
  assign div_tick = fast_raw & ((div_cnt_q & div_mask) == div_mask); // R15

  // source switching waits until the target is running
  assign src_tgt = (div_code != oscsc_pkg::DIV_SLOW) ? oscsc_pkg::SRC_FAST :
    slow_is_crystal ? oscsc_pkg::SRC_CRYSTAL :
    oscsc_pkg::SRC_SLOW_RC; // R04 R05 R15
  assign tgt_ready = (src_tgt == oscsc_pkg::SRC_FAST && fast_rc_run) ||
    (src_tgt == oscsc_pkg::SRC_SLOW_RC) ||
    (src_tgt == oscsc_pkg::SRC_CRYSTAL && xt_stable_q); // R17

  always_comb begin
    src_d = src_q;
    unique case (src_q)
      oscsc_pkg::SRC_FAST, oscsc_pkg::SRC_SLOW_RC: begin
        if (tgt_ready) begin
          src_d = src_tgt; // R05
        end
      end
      oscsc_pkg::SRC_CRYSTAL: begin
        if (!xt_stable_q) begin
          src_d = oscsc_pkg::SRC_SLOW_RC;
        end else if (tgt_ready) begin
          src_d = src_tgt;
        end
      end
      default: begin
        src_d = oscsc_pkg::SRC_FAST;
      end
    endcase
  end

  assign src_raw = (src_q == oscsc_pkg::SRC_FAST) ? div_tick :
                   (src_q == oscsc_pkg::SRC_CRYSTAL) ? xt_tick : slow_rc_osc_raw;

  assign fsub_raw = slow_is_crystal ? xt_tick : slow_rc_osc_raw; // R04
  assign sub_on = ~cpu_halt | slow_idle_en;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      src_q <= oscsc_pkg::SRC_FAST;
      div_cnt_q <= 6'h00;
      fast_rc_run <= 1'b0;
    end else begin
      src_q <= src_d;
      div_cnt_q <= fast_raw ? div_cnt_q + 6'h01 : div_cnt_q;
      fast_rc_run <= fast_run_d;
    end
  end

  // clock ticks and oscillator status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sys_tick <= 1'b0;
      fast_tick <= 1'b0;
      tbase_tick <= 1'b0;
      wdt_tick <= 1'b0;
      crystal_run <= 1'b0;
      crystal_stable <= 1'b0;
      crystal_low_power <= 1'b0;
    end else begin
      sys_tick <= src_raw & ~cpu_halt; // R14
      fast_tick <= fast_raw; // R13
      tbase_tick <= fsub_raw & sub_on; // R13 R14
      wdt_tick <= slow_rc_osc_raw; // R13 R16
      crystal_run <= xt_en;
      crystal_stable <= xt_stable_q;
      crystal_low_power <= xt_en & ~xt_speedup; // R07
    end
  end

  // helper: cycles since the last watchdog tick
  localparam logic [15:0] WDT_GAP_MAX =
    16'(oscsc_pkg::REF_HZ / oscsc_pkg::SLOW_RC_HZ + 2);
  logic [15:0] wdt_gap_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdt_gap_q <= 16'h0000;
    end else begin
      wdt_gap_q <= slow_rc_osc_raw ? 16'h0000 : wdt_gap_q + 16'h0001;
    end
  end

  a_sleep_gate: assert property (@(posedge ref_clk) disable iff (rst) // R14
    cpu_halt |=> !sys_tick)
    else $error("system tick while halted");

  a_fast_idle_off: assert property (@(posedge ref_clk) disable iff (rst) // R14
    (cpu_halt && !fast_idle_en) |=> !fast_rc_run)
    else $error("fast rc left running in halt");

  a_div_direct: assert property (@(posedge ref_clk) disable iff (rst) // R15
    (src_q == oscsc_pkg::SRC_FAST && div_code == 3'h0 && !cpu_halt)
    |=> (sys_tick == $past(fast_raw)))
    else $error("undivided fast clock lost ticks");

  a_wdt_alive: assert property (@(posedge ref_clk) disable iff (rst) // R16
    wdt_gap_q < WDT_GAP_MAX)
    else $error("watchdog clock stalled");

  a_xt_stable_wait: assert property (@(posedge ref_clk) disable iff (rst) // R06
    $rose(xt_stable_q) |-> ($past(xt_cnt_q) >= $past(xt_limit) - 14'h0001))
    else $error("crystal stable before start-up count");

  a_xt_mode_lock: assert property (@(posedge ref_clk) disable iff (rst) // R10
    (src_q == oscsc_pkg::SRC_CRYSTAL) |=> $stable(xt_speedup))
    else $error("crystal mode changed while system source");

  a_xt_switch: assert property (@(posedge ref_clk) disable iff (rst) // R17
    (src_q != oscsc_pkg::SRC_CRYSTAL ##1 src_q == oscsc_pkg::SRC_CRYSTAL)
    |-> $past(xt_stable_q))
    else $error("switched to crystal before stable");

  a_lp_keeps_run: assert property (@(posedge ref_clk) disable iff (rst) // R08
    (xt_stable_q && xt_en ##1 xt_en) |-> xt_stable_q)
    else $error("crystal dropped out while enabled");

  a_pin_share: assert property (@(posedge ref_clk) disable iff (rst) // R12
    xt_en |=> (crystal_pin_out_oe && !crystal_pin_in_oe))
    else $error("crystal pins released while crystal on");

  a_slow_switch: assert property (@(posedge ref_clk) disable iff (rst) // R05
    (src_tgt == oscsc_pkg::SRC_SLOW_RC && src_q == oscsc_pkg::SRC_FAST)
    |=> (src_q == oscsc_pkg::SRC_SLOW_RC))
    else $error("slow rc switch not taken in one cycle");
endmodule // oscsc_clock_ctrl

//--- oscsc_pkg.sv
// oscillator source select: register map, field layout and timing constants
// Operation
// (R01) fast rc, slow crystal and slow rc sources
// (R02) fast rc runs at 8, 12 or 16 MHz
// (R03) software matches frequency select to configuration
// (R04) slow_src_sel picks crystal or slow rc
// (R05) sysclk_div_sel picks fast or slow, live
// (R06) crystal_enable starts crystal, then start-up delay
// (R07) crystal_speedup 0 low power, 1 speed-up
// (R08) speed-up starts fast, low power keeps running
// (R09) software settles crystal mode before selecting it
// (R10) crystal mode frozen while crystal drives system
// (R11) both modes work, low power starts slower
// (R12) unused crystal pins become general I/O
// (R13) oscillators also clock watchdog and time base
// (R14) halt gates system clock, timer clock stays (code: time base stops in halt unless slow_idle_en is set)
// (R15) codes 000-110 divide fast by 1-64, 111 slow
// (R16) slow rc runs always, even in sleep
// (R17) switch to crystal only after stable flag
package oscsc_pkg;
  localparam longint REF_HZ = 100_000_000;
  localparam longint FAST_8_HZ = 8_000_000;
  localparam longint FAST_12_HZ = 12_000_000;
  localparam longint FAST_16_HZ = 16_000_000;
  localparam longint SLOW_RC_HZ = 32_000;

  // phase increments for a 32-bit accumulator clocked at REF_HZ
  localparam logic [31:0] INC_FAST_8 = 32'((FAST_8_HZ << 32) / REF_HZ);
  localparam logic [31:0] INC_FAST_12 = 32'((FAST_12_HZ << 32) / REF_HZ);
  localparam logic [31:0] INC_FAST_16 = 32'((FAST_16_HZ << 32) / REF_HZ);
  localparam logic [31:0] INC_SLOW_RC = 32'((SLOW_RC_HZ << 32) / REF_HZ);

  localparam logic [7:0] ADDR_SYSCLK_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FAST_RC_CTRL = 8'h01;
  localparam logic [7:0] ADDR_CRYSTAL_CTRL = 8'h02;
  localparam logic [7:0] ADDR_PIN_SHARE = 8'h03;

  localparam int SCC_DIV_LSB = 5;
  localparam int SCC_SRC_BIT = 2;
  localparam int SCC_FAST_IDLE_BIT = 1;
  localparam int SCC_SLOW_IDLE_BIT = 0;
  localparam int FRC_FREQ_LSB = 2;
  localparam int FRC_STABLE_BIT = 1;
  localparam int FRC_EN_BIT = 0;
  localparam int XTC_SPEEDUP_BIT = 2;
  localparam int XTC_STABLE_BIT = 1;
  localparam int XTC_EN_BIT = 0;
  localparam int PIN_GPIO_BIT = 0;
  localparam int PIN_OUT1_BIT = 1;
  localparam int PIN_OUT2_BIT = 2;
  localparam int PIN_OE1_BIT = 3;
  localparam int PIN_OE2_BIT = 4;
  localparam int PIN_IN1_BIT = 5;

  localparam logic [7:0] SCC_WMASK = 8'hE7;
  localparam logic [7:0] FRC_WMASK = 8'h0D;
  localparam logic [7:0] XTC_WMASK = 8'h05;
  localparam logic [7:0] PIN_WMASK = 8'h1F;

  localparam logic [7:0] RST_SYSCLK_CTRL = 8'h00;
  localparam logic [7:0] RST_FAST_RC_CTRL = 8'h01;
  localparam logic [7:0] RST_CRYSTAL_CTRL = 8'h00;
  localparam logic [7:0] RST_PIN_SHARE = 8'h00;

  localparam logic [2:0] DIV_SLOW = 3'h7;
  localparam logic [1:0] FREQ_8 = 2'h0;
  localparam logic [1:0] FREQ_12 = 2'h1;
  localparam logic [1:0] FREQ_16 = 2'h2;

  // crystal start-up, in crystal rising edges
  localparam logic [13:0] XT_START_SPEEDUP = 14'h0400;
  localparam logic [13:0] XT_START_LOWPWR = 14'h2000;

  typedef enum logic [1:0] {
    SRC_FAST = 2'b00,
    SRC_SLOW_RC = 2'b01,
    SRC_CRYSTAL = 2'b10
  } oscsc_src_t;
endpackage

//--- oscsc_sync2.sv
// two-flop synchroniser, one chain per bit
`timescale 1ns/10ps
module oscsc_sync2 #(
  parameter int W = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        meta_q[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta_q[i] <= d[i];
        q[i] <= meta_q[i];
      end
    end
  end
endmodule // oscsc_sync2

//--- oscsc_phase_tick.sv
// phase accumulator oscillator model: one-cycle tick per output period
`timescale 1ns/10ps
module oscsc_phase_tick (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [31:0] inc,
  output logic tick
);
  logic [31:0] acc_q;
  logic [32:0] sum;

  assign sum = {1'b0, acc_q} + {1'b0, inc};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_q <= 32'h0;
      tick <= 1'b0;
    end else begin
      acc_q <= run ? sum[31:0] : 32'h0;
      tick <= run & sum[32];
    end
  end
endmodule // oscsc_phase_tick

//--- oscillator_source_select_bench.sv
// self-checking bench for the clock source control block
`timescale 1ns/10ps
module oscillator_source_select_bench;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} oscsc_row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic cpu_halt = 1'b0;
  logic pin_in = 1'b0;
  logic pin_out = 1'b0;
  logic [7:0] rdata;
  logic in_drv, in_oe, out_drv, out_oe;
  logic sys_tick, fast_tick, tbase_tick, wdt_tick;
  logic fast_rc_run, crystal_run, crystal_stable, crystal_low_power;
  logic xt_on = 1'b0;
  logic tog = 1'b0;
  logic [7:0] v;
  int ph = 0;
  int xr = 0;
  int fc, sc, wc, tc, n, x0;
  int err_total = 0;
  int checks = 0;
  logic [7:0] rst_exp [4] = '{8'h00, 8'h03, 8'h00, 8'h00};
  int fexp [4] = '{80, 120, 160, 80};
  oscsc_row_t rows [7] = '{
    '{8'h00, 8'hFF, 8'hE7}, '{8'h00, 8'h00, 8'h00},
    '{8'h01, 8'h0D, 8'h0F}, '{8'h01, 8'h09, 8'h0B},
    '{8'h02, 8'h02, 8'h00}, '{8'h03, 8'hE0, 8'h00},
    '{8'h10, 8'hFF, 8'h00}};

  oscsc_clock_ctrl #(
    .XT_START_SPEEDUP(14'h0004),
    .XT_START_LOWPWR(14'h0008)
  ) u_oscsc_clock_ctrl (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cpu_halt(cpu_halt),
    .crystal_pin_in_level(pin_in), .crystal_pin_out_level(pin_out),
    .crystal_pin_in_drive(in_drv), .crystal_pin_in_oe(in_oe),
    .crystal_pin_out_drive(out_drv), .crystal_pin_out_oe(out_oe),
    .sys_tick(sys_tick), .fast_tick(fast_tick), .tbase_tick(tbase_tick),
    .wdt_tick(wdt_tick), .fast_rc_run(fast_rc_run),
    .crystal_run(crystal_run), .crystal_stable(crystal_stable),
    .crystal_low_power(crystal_low_power)
  );

  always #5 ref_clk = ~ref_clk;

  // pads with pull-downs; the crystal toggles every 15 cycles while on
  always @(posedge ref_clk) begin
    pin_out <= out_oe ? out_drv : 1'b0;
    pin_in <= xt_on ? tog : (in_oe ? in_drv : 1'b0);
    if (!xt_on) begin
      ph <= 0;
      tog <= 1'b0;
    end else if (ph == 14) begin
      ph <= 0;
      tog <= ~tog;
      if (!tog) begin
        xr <= xr + 1;
      end
    end else begin
      ph <= ph + 1;
    end
  end

  task automatic summarize;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp, input int tol);
    checks++;
    if (got < exp - tol || got > exp + tol) begin
      err_total++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic count(input int cyc);
    fc = 0;
    sc = 0;
    wc = 0;
    tc = 0;
    repeat (cyc) begin
      @(posedge ref_clk);
      #1;
      fc += int'(fast_tick === 1'b1);
      sc += int'(sys_tick === 1'b1);
      wc += int'(wdt_tick === 1'b1);
      tc += int'(tbase_tick === 1'b1);
    end
  endtask

  // bounded wait for the crystal start-up flag
  task automatic xwait;
    n = 0;
    while (crystal_stable !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask

  initial begin
    #600_000;
    err_total++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(8'(i));
      chk(v, rst_exp[i]);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(v, rows[i].e);
    end
    // pins handed to general I/O while the crystal is off
    wr(8'h03, 8'h0B);
    repeat (6) @(posedge ref_clk);
    #1 chk({in_oe, in_drv, out_oe}, 8'h06);
    rd(8'h03);
    chk(v, 8'h2B);
    wr(8'h03, 8'h15);
    repeat (6) @(posedge ref_clk);
    #1 chk({in_oe, out_drv, out_oe}, 8'h03);
    rd(8'h03);
    chk(v, 8'h55);
    wr(8'h03, 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr(8'h01, 8'(4 * f + 1));
      count(1000);
      near(fc, fexp[f], 1);
      near(sc, fc, 1);
    end
    wr(8'h01, 8'h09);
    for (int c = 0; c < 7; c++) begin
      wr(8'h00, 8'(32 * c));
      repeat (4) @(posedge ref_clk);
      count(2048);
      near(fc, 328, 1);
      near(sc, fc >> c, 1);
    end
    wr(8'h00, 8'hE0);
    count(6250);
    near(sc, 2, 1);
    near(tc, 2, 1);
    wr(8'h00, 8'h00);
    cpu_halt <= 1'b1;
    repeat (3) @(posedge ref_clk);
    count(6250);
    near(sc, 0, 0);
    near(tc, 0, 0);
    near(fc, 0, 0);
    near(wc, 2, 1);
    chk(fast_rc_run, 1'b0);
    wr(8'h00, 8'h03);
    count(6250);
    near(tc, 2, 1);
    near(fc, 1000, 1);
    chk(fast_rc_run, 1'b1);
    cpu_halt <= 1'b0;
    wr(8'h00, 8'h00);
    xt_on <= 1'b1;
    x0 = xr;
    wr(8'h02, 8'h05);
    xwait();
    near(xr - x0, 4, 0);
    chk({crystal_run, in_oe, out_oe}, 8'h05);
    wr(8'h02, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1 chk({crystal_stable, crystal_low_power}, 8'h03);
    wr(8'h02, 8'h00);
    xt_on <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk(crystal_stable, 1'b0);
    xt_on <= 1'b1;
    x0 = xr;
    wr(8'h02, 8'h01);
    xwait();
    near(xr - x0, 8, 0);
    wr(8'h02, 8'h05);
    wr(8'h00, 8'hE4);
    repeat (4) @(posedge ref_clk);
    x0 = xr;
    count(3000);
    near(sc, xr - x0, 1);
    near(tc, xr - x0, 1);
    wr(8'h02, 8'h01);
    rd(8'h02);
    chk(v, 8'h07);
    chk(crystal_low_power, 1'b0);
    wr(8'h00, 8'h00);
    repeat (4) @(posedge ref_clk);
    count(200);
    near(sc, fc, 1);
    // reset again in mid-run with the crystal toggling
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk({fast_rc_run, crystal_stable, crystal_run}, 8'h00);
    rst <= 1'b0;
    rd(8'h00);
    chk(v, 8'h00);
    rd(8'h02);
    chk(v, 8'h00);
    summarize();
  end
endmodule // oscillator_source_select_bench
